//--- nvr_array.sv
// Byte array of the memory, one write port and one read port
`timescale 1ns/10ps
module nvr_array
    import nvr_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              we,
    input  wire logic [ADDR_W-1:0] waddr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic [ADDR_W-1:0] raddr,
    output logic      [DATA_W-1:0] rdata
);
    // Contents are nonvolatile, so no reset touches them
    logic [DATA_W-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = mem[raddr];

endmodule : nvr_array

//--- nvr_master_model.sv
// Behavioural two-wire bus master that makes the serial clock and data
`timescale 1ns/10ps
module nvr_master_model (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    // Half period of the serial clock in system clock cycles
    int half = 5;

    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_cyc

    // **********************************************************
    // Framing: clock stands high between frames
    // **********************************************************
    task automatic start();
        if (scl == 1'b0) begin
            wait_cyc(1);
            sda_low = 1'b0;
            wait_cyc(half - 1);
            scl = 1'b1;
        end
        wait_cyc(half);
        sda_low = 1'b1;
        wait_cyc(half);
        scl = 1'b0;
    endtask : start

    task automatic stop();
        wait_cyc(1);
        sda_low = 1'b1;
        wait_cyc(half - 1);
        scl = 1'b1;
        wait_cyc(half);
        sda_low = 1'b0;
        wait_cyc(half);
    endtask : stop

    // One bit; the line is read just after the rise and at the end of high
    task automatic clk_bit(input logic b, output logic r_rise,
                           output logic r_late);
        wait_cyc(1);
        sda_low = ~b;
        wait_cyc(half - 1);
        scl = 1'b1;
        wait_cyc(1);
        r_rise = sda;
        wait_cyc(half - 1);
        r_late = sda;
        scl = 1'b0;
    endtask : clk_bit
endmodule : nvr_master_model

//--- nvr_pkg.sv
// Constants, enumerations and timing counts of the serial memory slave
//
// Overview of operation
// - The slave answers only when the three select bits of the address byte equal its strap inputs.
// - A select strap left open reads as low because its pad is pulled down.
// - Incoming data is sampled on the rising clock edge and outgoing data changes on the falling edge.
// - While write protect is high no array location is written, while low all are writable.
// - An open write protect input reads as low, so the array defaults to writable.
// - One of 8192 byte locations is chosen by the low 13 bits of the two-byte address.
// - The upper 3 bits of the two-byte address are ignored.
// - Each data byte received while write protect is low is committed to the array as soon as it has been fully received.
// - Any write is finished before the next transaction can arrive, so there is never a busy state.
// - The data line is only ever pulled low or released, forming a wired-AND.
// - Serial clocks up to 1 MHz are accepted; the master clocks at 12.5 MHz, later at about 3.1 MHz.
// - The address byte holds the type code in bits 7-4, select bits in 3-1 and read flag in bit 0.
// - The address advances after each byte and wraps from 1fff to 0000 with no burst limit.
// - The array write happens after the eighth data bit, so a START or STOP before it aborts.
// - Reads continue while the master acknowledges and stop when it withholds the acknowledge.
package nvr_pkg;

    // **********************************************************
    // Array geometry
    // **********************************************************
    localparam int          ADDR_W      = 13;
    localparam int          DATA_W      = 8;
    localparam int          DEPTH       = 8192;
    localparam logic [12:0] ADDR_RST    = 13'h0000;

    // **********************************************************
    // Address byte fields
    // **********************************************************
    localparam int          TYPE_MSB    = 7;
    localparam int          TYPE_LSB    = 4;
    localparam int          SEL_MSB     = 3;
    localparam int          SEL_LSB     = 1;
    localparam int          RW_BIT      = 0;
    localparam int          HI_KEEP_MSB = 4;
    localparam logic [3:0]  LAST_BIT    = 4'h7;
    localparam logic [3:0]  ACK_SLOT    = 4'h8;

    // **********************************************************
    // Timing
    // **********************************************************
    localparam int          CLK_PERIOD_NS = 8;
    localparam int          SCL_PERIOD_NS = 1000;
    localparam int          SCL_MIN_CYC   = SCL_PERIOD_NS / CLK_PERIOD_NS;

    // **********************************************************
    // Protocol states and byte roles
    // **********************************************************
    typedef enum logic [2:0] {
        ST_IDLE, ST_RX, ST_RXACK, ST_TX, ST_TXACK
    } nvr_state_t;

    typedef enum logic [1:0] {
        K_DEV, K_HI, K_LO, K_DATA
    } nvr_kind_t;

endpackage : nvr_pkg

//--- nvr_slave.sv
// Serial two-wire slave front end of the byte-organised memory
`timescale 1ns/10ps
module nvr_slave
    import nvr_pkg::*;
#(
    // Value arbitrary, stands in for the fixed device type code
    parameter logic [3:0] DEV_TYPE_CODE = 4'h5
) (
    input  wire logic       CLOCK,
    input  wire logic       SRST,
    input  wire logic       SCL,
    input  wire logic       SDA_IN,
    output logic            SDA_OUT,
    output logic            SDA_OE,
    input  wire logic [2:0] DEVICE_SELECT_STRAPS,
    input  wire logic       WRITE_PROTECT
);

    // **********************************************************
    // State
    // **********************************************************
    typedef struct packed {
        logic              scl_d;
        logic              sda_d;
        nvr_state_t        state;
        nvr_kind_t         kind;
        logic [3:0]        cnt;
        logic [7:0]        shreg;
        logic [ADDR_W-1:0] addr;
        logic              hit;
        logic              rw;
        logic              nak;
        logic              oe;
        logic              we;
        logic [ADDR_W-1:0] waddr;
        logic [DATA_W-1:0] wdata;
    } nvr_slave_t;

    nvr_slave_t        st;
    nvr_slave_t        next_st;
    logic [5:0]        pins_s;
    logic              scl_s;
    logic              sda_s;
    logic [2:0]        sel_s;
    logic              wp_s;
    logic              rise;
    logic              fall;
    logic              start;
    logic              stop;
    logic [7:0]        rx_byte;
    logic [DATA_W-1:0] rdata;

    // **********************************************************
    // Pin sampling
    // **********************************************************
    // Open straps and write protect arrive low from pad pull-downs
    // Two-stage sampling at 125 MHz leaves ample margin at 1 MHz
    nvr_sync #(
        .W (6)
    ) u_sync (
        .clk  (CLOCK),
        .srst (SRST),
        .din  ({SCL, SDA_IN, DEVICE_SELECT_STRAPS, WRITE_PROTECT}),
        .dout (pins_s)
    );

    assign scl_s = pins_s[5];
    assign sda_s = pins_s[4];
    assign sel_s = pins_s[3:1];
    assign wp_s  = pins_s[0];

    // **********************************************************
    // Bus event detection
    // **********************************************************
    assign rise    = scl_s & ~st.scl_d;
    assign fall    = ~scl_s & st.scl_d;
    assign start   = scl_s & st.scl_d & st.sda_d & ~sda_s;
    assign stop    = scl_s & st.scl_d & ~st.sda_d & sda_s;
    assign rx_byte = {st.shreg[6:0], sda_s};

    // **********************************************************
    // Array
    // **********************************************************
    nvr_array u_array (
        .clk   (CLOCK),
        .we    (st.we),
        .waddr (st.waddr),
        .wdata (st.wdata),
        .raddr (st.addr),
        .rdata (rdata)
    );

    // **********************************************************
    // Protocol engine
    // **********************************************************
    always_comb begin
        next_st       = st;
        next_st.scl_d = scl_s;
        next_st.sda_d = sda_s;
        next_st.we    = 1'b0;
        if (start) begin
            // Abort anything in progress, expect an address byte
            next_st.state = ST_RX;
            next_st.kind  = K_DEV;
            next_st.cnt   = 4'h0;
            next_st.oe    = 1'b0;
        end else if (stop) begin
            next_st.state = ST_IDLE;
            next_st.oe    = 1'b0;
        end else begin
            unique case (st.state)
                ST_IDLE: begin
                    next_st.oe = 1'b0;
                end
                ST_RX: begin
                    if (rise && st.cnt != ACK_SLOT) begin
                        next_st.shreg = rx_byte;
                        next_st.cnt   = st.cnt + 4'h1;
                        if (st.cnt == LAST_BIT) begin
                            unique case (st.kind)
                                K_DEV: begin
                                    next_st.hit =
                                        rx_byte[TYPE_MSB:TYPE_LSB]
                                            == DEV_TYPE_CODE &&
                                        rx_byte[SEL_MSB:SEL_LSB]
                                            == sel_s;
                                    next_st.rw = rx_byte[RW_BIT];
                                end
                                K_HI: begin
                                    // Top three bits dropped
                                    next_st.addr[12:8] =
                                        rx_byte[HI_KEEP_MSB:0];
                                end
                                K_LO: begin
                                    next_st.addr[7:0] = rx_byte;
                                end
                                K_DATA: begin
                                    // Commit on eighth bit
                                    next_st.we    = ~wp_s;
                                    next_st.waddr = st.addr;
                                    next_st.wdata = rx_byte;
                                    next_st.addr  = st.addr + 13'h1;
                                end
                            endcase
                        end
                    end else if (fall && st.cnt == ACK_SLOT) begin
                        if (st.kind == K_DEV && !st.hit) begin
                            next_st.state = ST_IDLE;
                        end else begin
                            next_st.oe    = 1'b1;
                            next_st.state = ST_RXACK;
                        end
                    end
                end
                ST_RXACK: begin
                    if (fall) begin
                        next_st.oe  = 1'b0;
                        next_st.cnt = 4'h0;
                        if (st.kind == K_DEV && st.rw) begin
                            next_st.state = ST_TX;
                            next_st.shreg = {rdata[6:0], 1'b0};
                            next_st.oe    = ~rdata[7];
                        end else begin
                            next_st.state = ST_RX;
                            unique case (st.kind)
                                K_DEV:   next_st.kind = K_HI;
                                K_HI:    next_st.kind = K_LO;
                                K_LO:    next_st.kind = K_DATA;
                                K_DATA:  next_st.kind = K_DATA;
                            endcase
                        end
                    end
                end
                ST_TX: begin
                    if (fall) begin
                        if (st.cnt == LAST_BIT) begin
                            // Release for the master's acknowledge
                            next_st.oe    = 1'b0;
                            next_st.addr  = st.addr + 13'h1;
                            next_st.state = ST_TXACK;
                        end else begin
                            next_st.oe    = ~st.shreg[7];
                            next_st.shreg = {st.shreg[6:0], 1'b0};
                            next_st.cnt   = st.cnt + 4'h1;
                        end
                    end
                end
                ST_TXACK: begin
                    if (rise) begin
                        next_st.nak = sda_s;
                    end else if (fall) begin
                        if (st.nak) begin
                            next_st.state = ST_IDLE;
                        end else begin
                            next_st.state = ST_TX;
                            next_st.cnt   = 4'h0;
                            next_st.shreg = {rdata[6:0], 1'b0};
                            next_st.oe    = ~rdata[7];
                        end
                    end
                end
                default: begin
                    next_st.state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            st       <= '0;
            st.state <= ST_IDLE;
            st.kind  <= K_DEV;
            st.addr  <= ADDR_RST;
        end else begin
            st <= next_st;
        end
    end

    // Line is only pulled low, never driven high
    always_ff @(posedge CLOCK) begin
        SDA_OUT <= 1'b0;
    end

    assign SDA_OE = st.oe;

    // **********************************************************
    // Checks
    // **********************************************************
    sequence s_last_data_bit;
        st.state == ST_RX && st.kind == K_DATA &&
            st.cnt == LAST_BIT && rise && !start && !stop;
    endsequence

    sequence s_write_slot;
        st.we ##1 !st.we;
    endsequence

    a_select_match: assert property (@(posedge CLOCK) disable iff (SRST)
        st.state == ST_RXACK && st.kind == K_DEV
            |-> st.shreg[SEL_MSB:SEL_LSB] == sel_s)
        else $error("acknowledged an address with wrong select bits");

    a_drive_on_fall: assert property (@(posedge CLOCK) disable iff (SRST)
        $rose(st.oe) |-> $past(fall))
        else $error("data line pulled low outside a falling clock edge");

    a_sample_on_rise: assert property (@(posedge CLOCK) disable iff (SRST)
        $past(st.state) == ST_RX && st.state == ST_RX &&
            st.cnt == $past(st.cnt) + 4'h1 |-> $past(rise))
        else $error("bit taken in without a rising clock edge");

    a_protect_blocks: assert property (@(posedge CLOCK) disable iff (SRST)
        s_last_data_bit ##0 wp_s |=> !st.we [*2])
        else $error("array written while write protect high");

    a_write_commit: assert property (@(posedge CLOCK) disable iff (SRST)
        s_last_data_bit ##0 !wp_s |=> s_write_slot ##0
            st.wdata == $past(rx_byte, 2) &&
            st.waddr == $past(st.addr, 2))
        else $error("received byte not committed at once");

    a_upper_ignored: assert property (@(posedge CLOCK) disable iff (SRST)
        st.state == ST_RXACK && st.kind == K_HI
            |-> st.addr[12:8] == st.shreg[HI_KEEP_MSB:0])
        else $error("upper address bits not discarded");

    a_addr_advance: assert property (@(posedge CLOCK) disable iff (SRST)
        $past(st.state) == ST_TX && st.state == ST_TXACK
            |-> st.addr == $past(st.addr) + 13'h1)
        else $error("address did not advance after a sent byte");

    a_open_drain: assert property (@(posedge CLOCK) disable iff (SRST)
        SDA_OE |-> ##1 !SDA_OUT)
        else $error("data line driven high");

    a_nack_ends: assert property (@(posedge CLOCK) disable iff (SRST)
        st.state == ST_TXACK && st.nak && fall && !start && !stop
            |=> st.state == ST_IDLE && !SDA_OE)
        else $error("read went on after no acknowledge");

    a_protect_acks: assert property (@(posedge CLOCK) disable iff (SRST)
        st.state == ST_RX && st.kind == K_DATA && st.cnt == ACK_SLOT &&
            fall && !start && !stop |=> SDA_OE && st.state == ST_RXACK)
        else $error("data byte not acknowledged");

    a_start_ready: assert property (@(posedge CLOCK) disable iff (SRST)
        start |=> st.state == ST_RX && st.kind == K_DEV && !SDA_OE)
        else $error("start did not ready the slave");

    a_other_ignored: assert property (@(posedge CLOCK) disable iff (SRST)
        st.state == ST_RX && st.kind == K_DEV && st.cnt == ACK_SLOT &&
            !st.hit && fall && !start && !stop
            |=> st.state == ST_IDLE && !SDA_OE)
        else $error("address of another device acknowledged");

    a_abort_no_write: assert property (@(posedge CLOCK) disable iff (SRST)
        (start || stop) && st.state == ST_RX && st.kind == K_DATA
            |=> !st.we)
        else $error("array written after an aborted byte");

    a_ack_release: assert property (@(posedge CLOCK) disable iff (SRST)
        st.state == ST_TX && st.cnt == LAST_BIT && fall && !start && !stop
            |=> st.state == ST_TXACK && !SDA_OE)
        else $error("data line not released for the master acknowledge");

endmodule : nvr_slave

//--- nvr_sync.sv
// Two flip-flop synchroniser for the pin inputs
`timescale 1ns/10ps
module nvr_sync #(
    parameter int W = 6
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } nvr_sync_t;

    nvr_sync_t st;
    nvr_sync_t next_st;

    always_comb begin
        next_st.meta = din;
        next_st.sync = st.meta;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.sync;

endmodule : nvr_sync

//--- test_i2c_serial_nvram_slave.sv
// Self-checking bench of the serial memory slave against a byte model
`timescale 1ns/10ps
`define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        n_errors++; \
        $display("mismatch at %0t got %0h exp %0h", $time, got, exp); \
    end \
end
module test_i2c_serial_nvram_slave;
    import nvr_pkg::*;
    // Value arbitrary, stands in for the device type code
    localparam logic [3:0] TYPE = 4'h5;
    logic            CLOCK;
    logic            SRST;
    logic            SCL;
    logic            SDA_OUT;
    logic            SDA_OE;
    logic            WRITE_PROTECT;
    logic [2:0]      DEVICE_SELECT_STRAPS;
    logic            m_low;
    logic            sda;
    int              n_errors = 0;
    int              samples_checked = 0;
    logic [7:0]      mem [int];
    int              cur = 0;
    logic [15:0]     a;
    logic [7:0]      q;
    logic            ack;
    logic            rr;
    logic            rl;

    assign sda = ~((SDA_OE & ~SDA_OUT) | m_low);

    nvr_slave #(.DEV_TYPE_CODE(TYPE)) i_dut (
        .CLOCK(CLOCK), .SRST(SRST), .SCL(SCL), .SDA_IN(sda),
        .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
        .DEVICE_SELECT_STRAPS(DEVICE_SELECT_STRAPS),
        .WRITE_PROTECT(WRITE_PROTECT)
    );
    nvr_master_model i_m (
        .clk(CLOCK), .sda(sda), .scl(SCL), .sda_low(m_low)
    );

    initial begin
        CLOCK = 1'b0;
        forever #4 CLOCK = ~CLOCK;
    end

    always @(posedge CLOCK) begin
        if (SDA_OE === 1'b1) `CHK(SDA_OUT, 1'b0)
    end

    task automatic end_sim();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    // **********************************************************
    // Byte level helpers
    // **********************************************************
    task automatic xfer(input logic [7:0] d, input logic mack,
                        output logic [7:0] r, output logic sack);
        for (int i = 7; i >= 0; i--) begin
            i_m.clk_bit(d[i], rr, rl);
            r[i] = rl;
            `CHK(rr, rl)
        end
        i_m.clk_bit(mack, rr, sack);
    endtask : xfer

    task automatic dev(input logic [7:0] b, input logic exp);
        i_m.start();
        xfer(b, 1'b1, q, ack);
        `CHK(ack, exp)
    endtask : dev

    task automatic wr_byte(input logic [7:0] d);
        xfer(d, 1'b1, q, ack);
        `CHK(ack, 1'b0)
    endtask : wr_byte

    task automatic set_addr(input logic [15:0] adr);
        dev({TYPE, DEVICE_SELECT_STRAPS, 1'b0}, 1'b0);
        wr_byte(adr[15:8]);
        wr_byte(adr[7:0]);
        cur = int'(adr[12:0]);
    endtask : set_addr

    task automatic wr(input logic [15:0] adr, input int n);
        logic [7:0] d;
        set_addr(adr);
        repeat (n) begin
            d = 8'($urandom);
            wr_byte(d);
            if (WRITE_PROTECT == 1'b0) mem[cur] = d;
            cur = (cur + 1) % DEPTH;
        end
        i_m.stop();
    endtask : wr

    task automatic rd(input int n);
        dev({TYPE, DEVICE_SELECT_STRAPS, 1'b1}, 1'b0);
        for (int k = 0; k < n; k++) begin
            xfer(8'hff, k == n - 1, q, ack);
            `CHK(q, mem[cur])
            cur = (cur + 1) % DEPTH;
        end
        i_m.stop();
    endtask : rd

    initial begin
        repeat (60000) @(posedge CLOCK);
        n_errors++;
        end_sim();
    end

    // **********************************************************
    // Main sequence
    // **********************************************************
    initial begin
        logic [2:0] s;
        SRST                 = 1'b1;
        WRITE_PROTECT        = 1'b0;
        DEVICE_SELECT_STRAPS = 3'h0;
        void'($urandom(92847));
        repeat (6) @(posedge CLOCK);
        @(negedge CLOCK);
        SRST = 1'b0;
        repeat (3) @(negedge CLOCK);
        for (int k = 0; k < 8; k++) begin
            s = 3'(k);
            DEVICE_SELECT_STRAPS = s;
            dev({TYPE, s, 1'b0}, 1'b0);
            i_m.stop();
            dev({TYPE, s ^ 3'(1 + $urandom % 7), 1'b0}, 1'b1);
            i_m.stop();
            dev({TYPE ^ 4'h8, s, 1'b1}, 1'b1);
            i_m.stop();
        end
        DEVICE_SELECT_STRAPS = 3'($urandom);
        a = 16'($urandom);
        wr(a, 4);
        set_addr(a);
        rd(4);
        wr({3'($urandom), 13'h1fff}, 3);
        set_addr(16'h1fff);
        rd(3);
        a = {3'h0, 13'($urandom % 4000)};
        wr(a, 3);
        WRITE_PROTECT = 1'b1;
        wr(a, 2);
        rd(1);
        WRITE_PROTECT = 1'b0;
        set_addr(a);
        rd(2);
        set_addr(a);
        for (int i = 0; i < 4; i++) i_m.clk_bit(1'b0, rr, rl);
        i_m.stop();
        set_addr(a);
        rd(1);
        set_addr(a);
        xfer(8'h3c, 1'b1, q, ack);
        `CHK(ack, 1'b0)
        mem[cur] = 8'h3c;
        cur = (cur + 1) % DEPTH;
        rd(1);
        set_addr(a);
        rd(1);
        i_m.half = 20;
        a = 16'($urandom);
        wr(a, 2);
        set_addr(a);
        rd(2);
        end_sim();
    end
endmodule : test_i2c_serial_nvram_slave
